// >>> inc/rdcfg_pkg.sv
/*
 Constants, types and field helpers shared by the re-driver B-side
 configuration slave. Assumes nothing of its surroundings.
*/
package rdcfg_pkg;

   // ----------------------------------------------------------------
   // Bus addressing
   // ----------------------------------------------------------------
   // Slave address value is arbitrary; device addressing is outside this block
   localparam logic [6:0] SLV_ADDR = 7'h58;
   localparam logic [7:0] REG_FIRST = 8'h00;
   localparam logic [7:0] REG_CFG_B = 8'h09;
   localparam logic [7:0] REG_TEST_A = 8'h0A;
   localparam logic [7:0] REG_TEST_B = 8'h0B;
   localparam logic [7:0] PTR_STEP = 8'h01;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;

   // ----------------------------------------------------------------
   // Reset values and counts
   // ----------------------------------------------------------------
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] TEST_RST = 8'h00;
   localparam logic [1:0] STRAP_CNT_RST = 2'h0;
   localparam logic [1:0] STRAP_LOAD_AT = 2'h2;
   localparam logic [1:0] STRAP_DONE = 2'h3;
   localparam logic [2:0] BIT_FIRST = 3'h0;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam int NUM_CH = 4;

   // ----------------------------------------------------------------
   // Field positions of the B-side byte (bit 0 of a field sits highest)
   // ----------------------------------------------------------------
   localparam int EQ0_POS = 7;
   localparam int EMPH0_POS = 4;
   localparam int SWING0_POS = 1;

   typedef enum {
      LNK_ADDR, LNK_ADDR_ACK, LNK_WDATA, LNK_WACK, LNK_RDATA, LNK_RACK, LNK_IDLE
   } rdcfg_lnk_st_t;

   function automatic logic [7:0] rdcfg_pack(input logic [2:0] eq, input logic [2:0] em,
                                             input logic [1:0] sw);
      logic [7:0] b;
      b = 8'h00;
      for (int i = 0; i < 3; i++) begin
         b[EQ0_POS - i] = eq[i];
         b[EMPH0_POS - i] = em[i];
      end
      for (int i = 0; i < 2; i++) begin
         b[SWING0_POS - i] = sw[i];
      end
      return b;
   endfunction

   function automatic logic [2:0] rdcfg_eq(input logic [7:0] b);
      return {b[EQ0_POS - 2], b[EQ0_POS - 1], b[EQ0_POS]};
   endfunction

   function automatic logic [2:0] rdcfg_emph(input logic [7:0] b);
      return {b[EMPH0_POS - 2], b[EMPH0_POS - 1], b[EMPH0_POS]};
   endfunction

   function automatic logic [1:0] rdcfg_swing(input logic [7:0] b);
      return {b[SWING0_POS - 1], b[SWING0_POS]};
   endfunction

endpackage

// >>> inc/rdcfg_link_if.sv
/*
 Carrier between the configuration core (reference clock) and the serial
 link engine (SCL clock). Assumes the core drives resets and read data.
*/
`timescale 1ns/1ps
interface rdcfg_link_if;
   logic link_rst_n;
   logic pwr_rst_n;
   logic byte_tog;
   logic byte_wr;
   logic [7:0] byte_dat;
   logic [7:0] rd_dat;
   logic sda_oe;

   modport lnk (
      input link_rst_n, pwr_rst_n, rd_dat,
      output byte_tog, byte_wr, byte_dat, sda_oe
   );
   modport core (
      output link_rst_n, pwr_rst_n, rd_dat,
      input byte_tog, byte_wr, byte_dat, sda_oe
   );
endinterface

// >>> core/rdcfg_link.sv
/*
 Serial link engine clocked by SCL: address match, byte shifting, ACK and
 read data driving. Assumes the core resets it on every START and STOP and
 keeps read data steady between byte events.
*/
`timescale 1ns/1ps
module rdcfg_link (
   // Link clock and data
   input wire logic scl_clk_in,
   input wire logic sda_in,
   // Core side
   rdcfg_link_if.lnk lif
);

   // ----------------------------------------------------------------
   // Receive side, rising SCL
   // ----------------------------------------------------------------
   rdcfg_pkg::rdcfg_lnk_st_t st_r, st_nxt;
   logic [2:0] cnt_r, cnt_nxt;
   logic [7:0] sh_r, sh_nxt;
   logic rw_r, rw_nxt;
   logic dummy_r, dummy_nxt;
   logic tog_r, tog_nxt;
   logic wr_r, wr_nxt;
   logic [7:0] dat_r, dat_nxt;

   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      sh_nxt = sh_r;
      rw_nxt = rw_r;
      dummy_nxt = dummy_r;
      tog_nxt = tog_r;
      wr_nxt = wr_r;
      dat_nxt = dat_r;
      case (st_r)
         rdcfg_pkg::LNK_ADDR: begin
            sh_nxt = {sh_r[6:0], sda_in};
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == rdcfg_pkg::BIT_LAST) begin
               if (sh_r[6:0] == rdcfg_pkg::SLV_ADDR) begin
                  st_nxt = rdcfg_pkg::LNK_ADDR_ACK;
                  rw_nxt = sda_in;
               end else begin
                  st_nxt = rdcfg_pkg::LNK_IDLE;
               end
            end
         end
         rdcfg_pkg::LNK_ADDR_ACK: begin
            st_nxt = rw_r ? rdcfg_pkg::LNK_RDATA : rdcfg_pkg::LNK_WDATA;
            dummy_nxt = 1'b1;
            cnt_nxt = rdcfg_pkg::BIT_FIRST;
         end
         rdcfg_pkg::LNK_WDATA: begin
            sh_nxt = {sh_r[6:0], sda_in};
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == rdcfg_pkg::BIT_LAST) begin
               st_nxt = rdcfg_pkg::LNK_WACK;
               dummy_nxt = 1'b0;
               // Leading offset byte is acknowledged but never stored
               if (!dummy_r) begin
                  dat_nxt = {sh_r[6:0], sda_in};
                  wr_nxt = 1'b1;
                  tog_nxt = ~tog_r;
               end
            end
         end
         rdcfg_pkg::LNK_WACK: begin
            st_nxt = rdcfg_pkg::LNK_WDATA;
         end
         rdcfg_pkg::LNK_RDATA: begin
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == rdcfg_pkg::BIT_LAST) begin
               // Early step gives the core a whole ACK slot to fetch the next byte
               st_nxt = rdcfg_pkg::LNK_RACK;
               wr_nxt = 1'b0;
               tog_nxt = ~tog_r;
            end
         end
         rdcfg_pkg::LNK_RACK: begin
            st_nxt = sda_in ? rdcfg_pkg::LNK_IDLE : rdcfg_pkg::LNK_RDATA;
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge scl_clk_in or negedge lif.link_rst_n) begin
      if (!lif.link_rst_n) begin
         st_r <= rdcfg_pkg::LNK_ADDR;
         cnt_r <= rdcfg_pkg::BIT_FIRST;
         sh_r <= 8'h00;
         rw_r <= 1'b0;
         dummy_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         rw_r <= rw_nxt;
         dummy_r <= dummy_nxt;
      end
   end

   // Survives frame resets so the core never sees a false byte event
   always_ff @(posedge scl_clk_in or negedge lif.pwr_rst_n) begin
      if (!lif.pwr_rst_n) begin
         tog_r <= 1'b0;
         wr_r <= 1'b0;
         dat_r <= 8'h00;
      end else begin
         tog_r <= tog_nxt;
         wr_r <= wr_nxt;
         dat_r <= dat_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Drive side, falling SCL
   // ----------------------------------------------------------------
   logic oe_r, oe_nxt;
   logic [7:0] tx_r, tx_nxt;

   always_comb begin
      oe_nxt = 1'b0;
      tx_nxt = tx_r;
      case (st_r)
         rdcfg_pkg::LNK_ADDR_ACK, rdcfg_pkg::LNK_WACK: begin
            oe_nxt = 1'b1;
         end
         rdcfg_pkg::LNK_RDATA: begin
            if (cnt_r == rdcfg_pkg::BIT_FIRST) begin
               tx_nxt = {lif.rd_dat[6:0], 1'b0};
               oe_nxt = ~lif.rd_dat[7];
            end else begin
               tx_nxt = {tx_r[6:0], 1'b0};
               oe_nxt = ~tx_r[7];
            end
         end
         default: begin
         end
      endcase
   end

   always_ff @(negedge scl_clk_in or negedge lif.link_rst_n) begin
      if (!lif.link_rst_n) begin
         oe_r <= 1'b0;
         tx_r <= 8'h00;
      end else begin
         oe_r <= oe_nxt;
         tx_r <= tx_nxt;
      end
   end

   assign lif.byte_tog = tog_r;
   assign lif.byte_wr = wr_r;
   assign lif.byte_dat = dat_r;
   assign lif.sda_oe = oe_r;

endmodule

// >>> core/rdcfg_top.sv
/*
 Top of the B-side configuration slave of a four-lane re-driver: strap
 loading, the configuration and test bytes, bus condition detection and the
 crossing to the SCL-clocked link engine. Assumes an open-drain SDA resolved
 outside, SCL as a clock, and strap pins steady around reset release.
*/
// Notes on behaviour
// - After reset every bit of the B-side byte is loaded from its strap pin.
// - The B-side byte holds equalizer bits 0-2 at 7-5, emphasis 0-2 at 4-2, swing 0-1 at 1-0.
// - The B-side byte changes over the bus only while the select input chooses bus mode.
// - One setting from the B-side byte drives all four B channels alike.
// - Bytes 10 and 11 are bus readable and writable and clear to zero at reset.
// - SDA falling while SCL is high starts a transfer.
// - SDA rising while SCL is high ends a transfer.
// - Only block reads and writes starting at the lowest byte are used.
// - A leading offset byte in a write is discarded.
`timescale 1ns/1ps
module rdcfg_top (
   // Clocks and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic scl_clk_in,
   // Serial data pin
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // Straps and mode
   input wire logic [2:0] eq_select_b_in,
   input wire logic [2:0] emph_ctrl_b_in,
   input wire logic [1:0] swing_ctrl_b_in,
   input wire logic cfg_source_sel_n_in,
   // Lane settings, three or two bits per channel, and the whole B-side byte
   output logic [11:0] eq_select_ch_out,
   output logic [11:0] emph_ctrl_ch_out,
   output logic [7:0] swing_ctrl_ch_out,
   output logic [7:0] b_lane_eq_output_ctrl_out
);

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic scl_s1_r, scl_s2_r, scl_d_r;
   logic sda_s1_r, sda_s2_r, sda_d_r;
   logic sel_s1_r, sel_s2_r;
   logic tog_s1_r, tog_s2_r, tog_d_r;
   logic [7:0] strap_s1_r, strap_s2_r;
   rdcfg_link_if lif ();

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         scl_d_r <= 1'b1;
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         sda_d_r <= 1'b1;
         sel_s1_r <= 1'b1;
         sel_s2_r <= 1'b1;
         tog_s1_r <= 1'b0;
         tog_s2_r <= 1'b0;
         tog_d_r <= 1'b0;
         strap_s1_r <= 8'h00;
         strap_s2_r <= 8'h00;
      end else begin
         scl_s1_r <= scl_clk_in;
         scl_s2_r <= scl_s1_r;
         scl_d_r <= scl_s2_r;
         sda_s1_r <= sda_in;
         sda_s2_r <= sda_s1_r;
         sda_d_r <= sda_s2_r;
         sel_s1_r <= cfg_source_sel_n_in;
         sel_s2_r <= sel_s1_r;
         tog_s1_r <= lif.byte_tog;
         tog_s2_r <= tog_s1_r;
         tog_d_r <= tog_s2_r;
         strap_s1_r <= rdcfg_pkg::rdcfg_pack(eq_select_b_in, emph_ctrl_b_in,
                                             swing_ctrl_b_in);
         strap_s2_r <= strap_s1_r;
      end
   end

   // ----------------------------------------------------------------
   // Bus conditions and frame reset of the link engine
   // ----------------------------------------------------------------
   logic start_det, stop_det, byte_evt;
   logic in_frame_r, in_frame_nxt;
   logic frame_clr_r, frame_clr_nxt;

   assign start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
   assign stop_det = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
   assign byte_evt = tog_s2_r ^ tog_d_r;

   // The engine is held in reset outside frames and released only while
   // SCL is low, so the release never races an SCL rising edge.
   always_comb begin
      in_frame_nxt = in_frame_r;
      frame_clr_nxt = frame_clr_r;
      if (start_det) begin
         in_frame_nxt = 1'b1;
         frame_clr_nxt = 1'b1;
      end else if (stop_det) begin
         in_frame_nxt = 1'b0;
         frame_clr_nxt = 1'b1;
      end else if (in_frame_r && !scl_s2_r) begin
         frame_clr_nxt = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         in_frame_r <= 1'b0;
         frame_clr_r <= 1'b1;
      end else begin
         in_frame_r <= in_frame_nxt;
         frame_clr_r <= frame_clr_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Byte pointer and register file
   // ----------------------------------------------------------------
   logic [7:0] ptr_r, ptr_nxt;
   logic [7:0] cfg_b_r, cfg_b_nxt;
   logic [7:0] test_a_r, test_a_nxt;
   logic [7:0] test_b_r, test_b_nxt;
   logic [7:0] rd_hold_r, rd_hold_nxt;
   logic [1:0] strap_cnt_r, strap_cnt_nxt;
   logic wr_ok;

   // Writes wait for the strap image so a bus write cannot be overwritten
   assign wr_ok = byte_evt & lif.byte_wr & (strap_cnt_r == rdcfg_pkg::STRAP_DONE);

   always_comb begin
      ptr_nxt = ptr_r;
      cfg_b_nxt = cfg_b_r;
      test_a_nxt = test_a_r;
      test_b_nxt = test_b_r;
      strap_cnt_nxt = strap_cnt_r;
      if (strap_cnt_r != rdcfg_pkg::STRAP_DONE) begin
         strap_cnt_nxt = strap_cnt_r + 2'h1;
      end
      if (strap_cnt_r == rdcfg_pkg::STRAP_LOAD_AT) begin
         cfg_b_nxt = strap_s2_r;
      end
      // Every transfer starts from the lowest byte
      if (start_det) begin
         ptr_nxt = rdcfg_pkg::REG_FIRST;
      end else if (byte_evt) begin
         ptr_nxt = ptr_r + rdcfg_pkg::PTR_STEP;
      end
      if (wr_ok) begin
         case (ptr_r)
            rdcfg_pkg::REG_CFG_B: begin
               // Bus write lands only in bus mode; otherwise dropped
               if (!sel_s2_r) begin
                  cfg_b_nxt = lif.byte_dat;
               end
            end
            rdcfg_pkg::REG_TEST_A: begin
               test_a_nxt = lif.byte_dat;
            end
            rdcfg_pkg::REG_TEST_B: begin
               test_b_nxt = lif.byte_dat;
            end
            default: begin
            end
         endcase
      end
      // Read image follows the pointer in every mode
      case (ptr_r)
         rdcfg_pkg::REG_CFG_B: rd_hold_nxt = cfg_b_r;
         rdcfg_pkg::REG_TEST_A: rd_hold_nxt = test_a_r;
         rdcfg_pkg::REG_TEST_B: rd_hold_nxt = test_b_r;
         default: rd_hold_nxt = rdcfg_pkg::RD_UNMAPPED;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ptr_r <= rdcfg_pkg::REG_FIRST;
         cfg_b_r <= rdcfg_pkg::CFG_RST;
         test_a_r <= rdcfg_pkg::TEST_RST;
         test_b_r <= rdcfg_pkg::TEST_RST;
         rd_hold_r <= rdcfg_pkg::RD_UNMAPPED;
         strap_cnt_r <= rdcfg_pkg::STRAP_CNT_RST;
      end else begin
         ptr_r <= ptr_nxt;
         cfg_b_r <= cfg_b_nxt;
         test_a_r <= test_a_nxt;
         test_b_r <= test_b_nxt;
         rd_hold_r <= rd_hold_nxt;
         strap_cnt_r <= strap_cnt_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Link engine
   // ----------------------------------------------------------------
   assign lif.link_rst_n = rst_n_in & ~frame_clr_r;
   assign lif.pwr_rst_n = rst_n_in;
   assign lif.rd_dat = rd_hold_r;

   rdcfg_link u_link (
      .scl_clk_in (scl_clk_in),
      .sda_in (sda_in),
      .lif (lif.lnk)
   );

   // Open drain: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe_out = lif.sda_oe;

   // ----------------------------------------------------------------
   // Lane settings
   // ----------------------------------------------------------------
   assign b_lane_eq_output_ctrl_out = cfg_b_r;

   for (genvar ch = 0; ch < rdcfg_pkg::NUM_CH; ch++) begin : g_ch
      assign eq_select_ch_out[ch*3 +: 3] = rdcfg_pkg::rdcfg_eq(cfg_b_r);
      assign emph_ctrl_ch_out[ch*3 +: 3] = rdcfg_pkg::rdcfg_emph(cfg_b_r);
      assign swing_ctrl_ch_out[ch*2 +: 2] = rdcfg_pkg::rdcfg_swing(cfg_b_r);
   end

endmodule

// >>> verif/rdcfg_checker.sv
/*
 Port-level assertions for the B-side configuration slave top.
 Assumes an open-drain SDA whose resolved level reaches sda_in.
*/
`timescale 1ns/1ps
module rdcfg_checker (
   // Clocks and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic scl_clk_in,
   // Serial data pin
   input wire logic sda_in,
   input wire logic sda_oe_out,
   // Straps and mode
   input wire logic [2:0] eq_select_b_in,
   input wire logic [2:0] emph_ctrl_b_in,
   input wire logic [1:0] swing_ctrl_b_in,
   input wire logic cfg_source_sel_n_in,
   // Lane settings
   input wire logic [11:0] eq_select_ch_out,
   input wire logic [11:0] emph_ctrl_ch_out,
   input wire logic [7:0] swing_ctrl_ch_out,
   input wire logic [7:0] b_lane_eq_output_ctrl_out
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);

   wire logic [7:0] cfg = b_lane_eq_output_ctrl_out;

   lane_eq_a: assert property (eq_select_ch_out == {4{cfg[5], cfg[6], cfg[7]}})
      else $error("equalizer lanes differ from config byte");
   lane_emph_a: assert property (emph_ctrl_ch_out == {4{cfg[2], cfg[3], cfg[4]}})
      else $error("emphasis lanes differ from config byte");
   lane_swing_a: assert property (swing_ctrl_ch_out == {4{cfg[0], cfg[1]}})
      else $error("swing lanes differ from config byte");
   strap_load_a: assert property ($rose(rst_n_in) |-> ##[3:5] cfg == {eq_select_b_in[0],
      eq_select_b_in[1], eq_select_b_in[2], emph_ctrl_b_in[0], emph_ctrl_b_in[1],
      emph_ctrl_b_in[2], swing_ctrl_b_in[0], swing_ctrl_b_in[1]})
      else $error("config byte not loaded from straps");
   reset_clear_a: assert property (disable iff (1'b0) !rst_n_in |->
      cfg == 8'h00 && eq_select_ch_out == 12'h000 && !sda_oe_out)
      else $error("outputs not cleared in reset");
   // Select input crosses two flops, so only judge once it has settled
   pin_mode_hold_a: assert property ((cfg_source_sel_n_in && $past(cfg_source_sel_n_in, 4)
      && $past(rst_n_in, 8)) |-> $stable(cfg)) else $error("config byte changed in pin mode");
   stop_release_a: assert property ((scl_clk_in && $rose(sda_in)) |-> ##[1:6] !sda_oe_out)
      else $error("data line held after stop");
   start_release_a: assert property ((scl_clk_in && $fell(sda_in)) |-> ##[1:6] !sda_oe_out)
      else $error("data line held after start");
   ack_seen_c: cover property (sda_oe_out);
endmodule

bind rdcfg_top rdcfg_checker u_chk (.*);

// >>> verif/rdcfg_i2c_master.sv
/*
 Behavioural I2C bus master driving SCL and pulling SDA low.
 Assumes the bench resolves SDA with a pull-up from all enables.
*/
`timescale 1ns/1ps
module rdcfg_i2c_master #(
   parameter time Q = 160ns
) (
   // Bus
   output logic scl_out,
   output logic sda_oe_out,
   input wire logic sda_in
);
   // SCL stands high between frames
   initial begin
      scl_out = 1'b1;
      sda_oe_out = 1'b0;
   end

   task automatic start_c;
      sda_oe_out = 1'b0;
      #Q scl_out = 1'b1;
      #Q sda_oe_out = 1'b1;
      #Q scl_out = 1'b0;
   endtask

   task automatic stop_c;
      #Q sda_oe_out = 1'b1;
      #Q scl_out = 1'b1;
      #Q sda_oe_out = 1'b0;
      #Q;
   endtask

   // Data changes only while SCL is low
   task automatic bit_c(input logic b, output logic s);
      #Q sda_oe_out = ~b;
      #Q scl_out = 1'b1;
      #Q s = sda_in;
      #Q scl_out = 1'b0;
   endtask

   task automatic wr_byte(input logic [7:0] d, output logic ack_n);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_c(d[i], s);
      end
      bit_c(1'b1, ack_n);
   endtask

   task automatic rd_byte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_c(1'b1, d[i]);
      end
      bit_c(last, s);
   endtask
endmodule

// >>> verif/rdcfg_tb_top.sv
/*
 Self-checking bench for the B-side configuration slave.
 Assumes the master model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
module rdcfg_tb_top;
   logic ref_clk = 1'b0;
   // Starts high so the asynchronous resets see a real falling edge
   logic rst_n = 1'b1;
   logic scl;
   logic m_oe;
   logic d_oe;
   logic d_out;
   logic [2:0] eq_s = 3'h6;
   logic [2:0] em_s = 3'h1;
   logic [1:0] sw_s = 2'h1;
   logic sel_n = 1'b0;
   logic [11:0] eq_ch;
   logic [11:0] em_ch;
   logic [7:0] sw_ch;
   logic [7:0] cfg;
   logic [7:0] wb [0:12];
   logic [7:0] rb [0:11];
   int n_fail = 0;
   int comparisons = 0;
   int cycles = 0;
   // Open-drain wire with pull-up: the device drives its data value only when enabled
   wire logic sda = ~m_oe & (d_oe ? d_out : 1'b1);

   always #5 ref_clk = ~ref_clk;

   rdcfg_i2c_master u_mst (.scl_out(scl), .sda_oe_out(m_oe), .sda_in(sda));
   rdcfg_top u_dut (
      .ref_clk_in(ref_clk), .rst_n_in(rst_n), .scl_clk_in(scl), .sda_in(sda),
      .sda_out(d_out), .sda_oe_out(d_oe), .eq_select_b_in(eq_s), .emph_ctrl_b_in(em_s),
      .swing_ctrl_b_in(sw_s), .cfg_source_sel_n_in(sel_n), .eq_select_ch_out(eq_ch),
      .emph_ctrl_ch_out(em_ch), .swing_ctrl_ch_out(sw_ch), .b_lane_eq_output_ctrl_out(cfg)
   );

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic summarize;
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_lanes(input logic [7:0] b, input logic [11:0] e, input logic [11:0] m,
                            input logic [7:0] s);
      chk(12'(cfg), 12'(b));
      chk(eq_ch, e);
      chk(em_ch, m);
      chk(12'(sw_ch), 12'(s));
   endtask

   task automatic wr_frame(input int n);
      logic a;
      u_mst.start_c();
      u_mst.wr_byte({rdcfg_pkg::SLV_ADDR, 1'b0}, a);
      chk(12'(a), 12'h000);
      for (int i = 0; i < n; i++) begin
         u_mst.wr_byte(wb[i], a);
         chk(12'(a), 12'h000);
      end
      u_mst.stop_c();
   endtask

   // Always a block from the lowest byte
   task automatic rd_frame;
      logic a;
      u_mst.start_c();
      u_mst.wr_byte({rdcfg_pkg::SLV_ADDR, 1'b1}, a);
      chk(12'(a), 12'h000);
      for (int i = 0; i < 12; i++) begin
         u_mst.rd_byte(i == 11, rb[i]);
      end
      u_mst.stop_c();
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_power_on;
      chk_lanes(8'h72, 12'hDB6, 12'h249, 8'h55);
      rd_frame();
      // Bytes below the B-side byte are not mapped here and read as zero
      for (int i = 0; i < 9; i++) begin
         chk(12'(rb[i]), 12'h000);
      end
      chk(12'(rb[9]), 12'h072);
      chk(12'(rb[10]), 12'h000);
      chk(12'(rb[11]), 12'h000);
   endtask

   // Leading byte 0x09 would misplace everything if it were stored
   task automatic t_bus_write;
      wb[0] = 8'h09;
      for (int i = 1; i < 10; i++) begin
         wb[i] = 8'h11;
      end
      wb[10] = 8'hA5;
      wb[11] = 8'h3C;
      wb[12] = 8'hC3;
      wr_frame(13);
      repeat (10) @(posedge ref_clk);
      #1;
      chk_lanes(8'hA5, 12'hB6D, 12'h924, 8'hAA);
      rd_frame();
      chk(12'(rb[8]), 12'h000);
      chk(12'(rb[9]), 12'h0A5);
      chk(12'(rb[10]), 12'h03C);
      chk(12'(rb[11]), 12'h0C3);
   endtask

   task automatic t_pin_mode;
      @(posedge ref_clk);
      #1 sel_n = 1'b1;
      repeat (5) @(posedge ref_clk);
      #1;
      wb[10] = 8'h0F;
      wb[11] = 8'h5A;
      wr_frame(12);
      repeat (10) @(posedge ref_clk);
      #1;
      chk_lanes(8'hA5, 12'hB6D, 12'h924, 8'hAA);
      rd_frame();
      chk(12'(rb[9]), 12'h0A5);
      chk(12'(rb[10]), 12'h05A);
      chk(12'(rb[11]), 12'h0C3);
      @(posedge ref_clk);
      #1 sel_n = 1'b0;
   endtask

   // Test bytes go back to zero once their checks are done
   task automatic t_restore;
      wb[10] = 8'hA5;
      wb[11] = 8'h00;
      wb[12] = 8'h00;
      wr_frame(13);
      rd_frame();
      chk(12'(rb[9]), 12'h0A5);
      chk(12'(rb[10]), 12'h000);
      chk(12'(rb[11]), 12'h000);
   endtask

   task automatic t_wrong_addr;
      logic a;
      u_mst.start_c();
      u_mst.wr_byte({rdcfg_pkg::SLV_ADDR ^ 7'h01, 1'b0}, a);
      chk(12'(a), 12'h001);
      u_mst.stop_c();
   endtask

   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 80000) begin
         n_fail++;
         summarize();
      end
   end

   initial begin
      #1 rst_n = 1'b0;
      repeat (16) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      repeat (12) @(posedge ref_clk);
      // Every bench drive, master included, lands one step after the edge
      #1;
      t_power_on();
      t_bus_write();
      t_pin_mode();
      t_restore();
      t_wrong_addr();
      summarize();
   end
endmodule
